// File: verilog/lsr_dev_end.sv
// Device end: full-status frame 2, OTP segment read and quick status.
// Assumes the master sends one byte per cycle at most and one frame at once.
//
// Functional notes
// R1: Positions in bytes 2-5, high byte first.
// R2: Secure position split over bytes 6-7.
// R3: Stall flags packed into byte 8.
// R4: OTP read returns the prepared segment.
// R5: OTP answer uses indirect identifier 0x3D.
// R6: Master prepares with type 7 first.
// R7: Master may prepare with type 8 instead.
// R8: Command and address bytes carry bit 7.
// R9: Type 8 carries application byte and filler.
// R10: OTP bytes 0 to 7 ascending.
// R11: Quick status: two bytes, direct identifier.
// R12: Quick status is reduced circuit summary.
// R13: Byte 1: end switch and address.
// R14: Byte 2: fault flags and temperature.
// R15: Quick status clears flags, causes persist.
// R16: Quick status identifier is dynamically allocated.
// R17: Master gives each node its own identifier.
// R18: Identifier parity bits in top two bits.
// R19: Foreign address leaves the node silent.
// R20: Inverted carry checksum closes every frame.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module lsr_dev_end (
    input  wire logic                clk,
    input  wire logic                rst_n,
    lsr_link_if.dev                  link,
    input  wire logic [6:0]          nodeAddress,
    input  wire logic [5:0]          prepareId,
    input  wire logic [5:0]          quickStatusId,
    input  wire logic [15:0]         actualPosition,
    input  wire logic [15:0]         targetPosition,
    input  wire logic [10:0]         securePosition,
    input  wire logic [2:0]          fullstepStallEnable,
    input  wire logic                fullDutyFlag,
    input  wire logic                fullDutyStallEnable,
    input  wire logic                absoluteStallFlag,
    input  wire logic                deltaStallLowFlag,
    input  wire logic                deltaStallHighFlag,
    input  wire logic [2:0]          stallMinSampleCount,
    input  wire logic                pwmJitterEnable,
    input  wire logic                endSwitchState,
    input  wire lsr_pkg::lsr_flags_t flagCause,
    input  wire logic [1:0]          tempInfo,
    input  wire logic                otpWrEn,
    input  wire logic [2:0]          otpWrAddr,
    input  wire logic [7:0]          otpWrData,
    output logic                     statusFlags0,
    output lsr_pkg::lsr_flags_t      statusFlags
);
    import lsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} lsr_dst_e;
    typedef enum logic [1:0] {P_NONE, P_FULL, P_OTP} lsr_pend_e;

    typedef struct packed {
        lsr_dst_e   st;
        lsr_pend_e  pend;
        logic       rx8;
        logic       txQuick;
        logic [3:0] cnt;
        logic [3:0] len;
        logic [7:0] sum;
        lsr_bytes_t buffer;
        lsr_bytes_t otp;
        lsr_flags_t flags;
        logic [7:0] txData;
        logic       txValid;
    } lsr_dev_s;

    lsr_dev_s   s;
    lsr_dev_s   next_s;
    logic       clrFlags;
    logic [7:0] cmdByte;
    logic [7:0] adrByte;
    logic       appOk;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of a received preparing frame depend on its form.
    assign cmdByte = s.rx8 ? s.buffer[1] : s.buffer[0];
    assign adrByte = s.rx8 ? s.buffer[2] : s.buffer[1];
    assign appOk   = !s.rx8 || (s.buffer[0] == APP_CMD);

    // Frame engine: header match, receive, then transmit the answer.
    always_comb begin
        next_s         = s;
        next_s.txValid = 1'b0;
        clrFlags       = 1'b0;
        if (otpWrEn) begin
            next_s.otp[otpWrAddr] = otpWrData;
        end
        case (s.st)
            D_IDLE: begin
                next_s.cnt = 4'h0;
                next_s.sum = 8'h00;
                if (link.pidValid) begin
                    // R18: parity checked by full match.
                    // R16: dynamic quick status identifier.
                    if (link.pid == pidOf(quickStatusId)) begin
                        // R11: two-byte direct answer.
                        // R13: end switch over address.
                        // R12: reduced summary of circuit.
                        // R14: flags above temperature info.
                        next_s.buffer[0] = {endSwitchState, nodeAddress};
                        next_s.buffer[1] = {s.flags, tempInfo};
                        next_s.len       = LEN_QUICK;
                        next_s.txQuick   = 1'b1;
                        next_s.st        = D_TX;
                    end else if (link.pid == pidOf(ID_READ)) begin
                        // R5: indirect read identifier.
                        next_s.len     = LEN_READ;
                        next_s.txQuick = 1'b0;
                        next_s.pend    = P_NONE;
                        case (s.pend)
                            P_OTP: begin
                                // R4: prepared segment returned.
                                // R10: bytes 0 to 7 ascending.
                                next_s.buffer = s.otp;
                                next_s.st     = D_TX;
                            end
                            P_FULL: begin
                                // R1: positions, high byte first.
                                // R2: secure position split.
                                // R3: stall byte layout.
                                next_s.buffer = {
                                    {absoluteStallFlag, deltaStallLowFlag,
                                     deltaStallHighFlag, stallMinSampleCount,
                                     fullDutyStallEnable, pwmJitterEnable},
                                    {fullstepStallEnable, ONE_BIT, fullDutyFlag,
                                     securePosition[10:8]},
                                    securePosition[7:0],
                                    targetPosition[7:0], targetPosition[15:8],
                                    actualPosition[7:0], actualPosition[15:8],
                                    {MARK_BIT, nodeAddress}};
                                next_s.st     = D_TX;
                            end
                            default: begin
                                // R19: nothing prepared, stay silent.
                                next_s.st = D_IDLE;
                            end
                        endcase
                    end else if (!prepareId[5] && link.pid == pidOf(prepareId)) begin
                        // R6: short preparing form.
                        next_s.rx8 = 1'b0;
                        next_s.len = LEN_PREP7;
                        next_s.st  = D_RX;
                    end else if (link.pid == pidOf(ID_PREP8)) begin
                        // R7: long preparing form.
                        next_s.rx8 = 1'b1;
                        next_s.len = LEN_PREP8;
                        next_s.st  = D_RX;
                    end
                end
            end
            D_RX: begin
                if (link.pidValid) begin
                    next_s.st = D_IDLE;  // A new header aborts a short frame.
                end else if (link.mValid) begin
                    if (s.cnt != s.len) begin
                        next_s.buffer[s.cnt[2:0]] = link.mData;
                        next_s.sum = addCarry(s.sum, link.mData);
                        next_s.cnt = s.cnt + 4'h1;
                    end else begin
                        next_s.st = D_IDLE;
                        // R20: bad checksum drops the frame.
                        if (link.mData == ~s.sum && appOk) begin
                            // R8: marked command and address.
                            // R19: only our address arms a read.
                            if (adrByte != {MARK_BIT, nodeAddress}) begin
                                next_s.pend = P_NONE;
                            end else if (cmdByte == {MARK_BIT, CMD_FULL}) begin
                                next_s.pend = P_FULL;
                            end else if (cmdByte == {MARK_BIT, CMD_OTP}) begin
                                next_s.pend = P_OTP;
                            end else begin
                                next_s.pend = P_NONE;
                            end
                        end
                    end
                end
            end
            D_TX: begin
                next_s.txValid = 1'b1;
                if (s.cnt != s.len) begin
                    next_s.txData = s.buffer[s.cnt[2:0]];
                    next_s.sum    = addCarry(s.sum, s.buffer[s.cnt[2:0]]);
                    next_s.cnt    = s.cnt + 4'h1;
                end else begin
                    // R20: checksum byte closes the answer.
                    next_s.txData = ~s.sum;
                    next_s.st     = D_IDLE;
                    clrFlags      = s.txQuick;
                end
            end
            default: begin
                next_s.st = D_IDLE;
            end
        endcase
        // R15: clear after report; a live cause wins over the clear.
        next_s.flags = (clrFlags ? '0 : s.flags) | flagCause;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; the whole OTP image resets to zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Link and status outputs come straight from state.
    assign link.sData   = s.txData;
    assign link.sValid  = s.txValid;
    assign statusFlags  = s.flags;
    assign statusFlags0 = s.flags[0];

endmodule : lsr_dev_end
`default_nettype wire

// File: include/lsr_pkg.sv
// Shared constants, types and helpers for the LIN read-back ends.
// Assumes both ends run on one 10 MHz clock and exchange whole bytes.
package lsr_pkg;

    // Identifiers and command codes.
    localparam logic [5:0] ID_READ   = 6'h3d;
    localparam logic [5:0] ID_PREP8  = 6'h3c;
    localparam logic [6:0] CMD_FULL  = 7'h01;
    localparam logic [6:0] CMD_OTP   = 7'h02;
    localparam logic [7:0] APP_CMD   = 8'h80;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic       MARK_BIT  = 1'b1;
    localparam logic       ONE_BIT   = 1'b1;

    // Data byte counts, checksum excluded.
    localparam logic [3:0] LEN_PREP7 = 4'h2;
    localparam logic [3:0] LEN_PREP8 = 4'h8;
    localparam logic [3:0] LEN_READ  = 4'h8;
    localparam logic [3:0] LEN_QUICK = 4'h2;

    // Response wait of the master, in ns, and its cycle count.
    localparam int         CLK_NS      = 100;
    localparam int         RESP_WAIT_NS = 2000;
    localparam logic [7:0] RESP_WAIT_CYC = 8'(RESP_WAIT_NS / CLK_NS);

    // Register map of the master end.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RD0    = 8'h08;
    localparam logic [7:0] REG_RD1    = 8'h0c;
    localparam int CTRL_KIND_LSB = 0;
    localparam int CTRL_ID_LSB   = 8;
    localparam int CTRL_CODE_LSB = 16;
    localparam int CTRL_ADDR_LSB = 24;

    typedef logic [5:0] lsr_flags_t;
    typedef logic [7:0][7:0] lsr_bytes_t;
    typedef enum logic [1:0] {KIND_PREP7, KIND_PREP8, KIND_READ, KIND_QUICK} lsr_kind_e;

    // Protected identifier: two parity bits above the 6-bit identifier.
    function automatic logic [7:0] pidOf(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction : pidOf

    // Checksum step: add with the carry folded back in.
    function automatic logic [7:0] addCarry(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction : addCarry

endpackage : lsr_pkg

// File: include/lsr_link_if.sv
// Byte-level LIN link between the master end and the device end.
// Assumes one shared clock; a valid is high for one cycle per byte or header.
`timescale 1ns/10ps
`default_nettype none
interface lsr_link_if;
    logic [7:0] pid;
    logic       pidValid;
    logic [7:0] mData;
    logic       mValid;
    logic [7:0] sData;
    logic       sValid;
    modport dev (input pid, pidValid, mData, mValid, output sData, sValid);
    modport mst (output pid, pidValid, mData, mValid, input sData, sValid);
endinterface : lsr_link_if
`default_nettype wire

// File: verilog/lsr_master_end.sv
// Master end: runs one LIN frame per order written over APB.
// Assumes an APB3 requester on the same clock; zero wait states.
`timescale 1ns/10ps
`default_nettype none
module lsr_master_end (
    input  wire logic         clk,
    input  wire logic         rst_n,
    lsr_link_if.mst           link,
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              busy
);
    import lsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {M_IDLE, M_HDR, M_TX, M_RX} lsr_mst_e;

    typedef struct packed {
        lsr_mst_e   st;
        lsr_kind_e  kind;
        logic [5:0] id;
        logic [6:0] code;
        logic [6:0] addr;
        lsr_bytes_t buffer;
        logic [3:0] cnt;
        logic [3:0] len;
        logic [7:0] sum;
        logic [7:0] waitCnt;
        logic       done;
        logic       ok;
        logic       noResp;
        logic [7:0] pid;
        logic       pidValid;
        logic [7:0] mData;
        logic       mValid;
        logic [31:0] rdata;
    } lsr_mst_s;

    lsr_mst_s s;
    lsr_mst_s next_s;
    logic     setup;
    logic     access;
    logic     mapped;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; reads are captured in setup so data leaves a flop.
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign mapped  = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                     (paddr == REG_RD0) || (paddr == REG_RD1);
    assign pready  = access;
    assign pslverr = access && !mapped;

    always_comb begin
        next_s          = s;
        next_s.pidValid = 1'b0;
        next_s.mValid   = 1'b0;
        if (setup && !pwrite) begin
            case (paddr)
                REG_STATUS: next_s.rdata = {28'h0000000, s.noResp, s.ok, s.done,
                                            s.st != M_IDLE};
                REG_RD0:    next_s.rdata = s.buffer[3:0];
                REG_RD1:    next_s.rdata = s.buffer[7:4];
                REG_CTRL:   next_s.rdata = {1'b0, s.addr, 1'b0, s.code, 2'h0, s.id,
                                            6'h00, s.kind};
                default:    next_s.rdata = 32'h00000000;
            endcase
        end
        case (s.st)
            M_IDLE: begin
                // An order written while busy is dropped without error.
                if (access && pwrite && paddr == REG_CTRL) begin
                    next_s.kind   = lsr_kind_e'(pwdata[CTRL_KIND_LSB +: 2]);
                    next_s.id     = pwdata[CTRL_ID_LSB +: 6];
                    next_s.code   = pwdata[CTRL_CODE_LSB +: 7];
                    next_s.addr   = pwdata[CTRL_ADDR_LSB +: 7];
                    next_s.done   = 1'b0;
                    next_s.ok     = 1'b0;
                    next_s.noResp = 1'b0;
                    next_s.st     = M_HDR;
                end
            end
            M_HDR: begin
                next_s.pidValid = 1'b1;
                next_s.cnt      = 4'h0;
                next_s.sum      = 8'h00;
                next_s.waitCnt  = 8'h00;
                next_s.buffer   = '0;
                case (s.kind)
                    KIND_PREP7: begin
                        next_s.pid       = pidOf(s.id);
                        next_s.buffer[0] = {MARK_BIT, s.code};
                        next_s.buffer[1] = {MARK_BIT, s.addr};
                        next_s.len       = LEN_PREP7;
                        next_s.st        = M_TX;
                    end
                    KIND_PREP8: begin
                        next_s.pid       = pidOf(ID_PREP8);
                        next_s.buffer    = {{5{FILL_BYTE}}, {MARK_BIT, s.addr},
                                            {MARK_BIT, s.code}, APP_CMD};
                        next_s.len       = LEN_PREP8;
                        next_s.st        = M_TX;
                    end
                    KIND_READ: begin
                        next_s.pid = pidOf(ID_READ);
                        next_s.len = LEN_READ;
                        next_s.st  = M_RX;
                    end
                    default: begin
                        next_s.pid = pidOf(s.id);
                        next_s.len = LEN_QUICK;
                        next_s.st  = M_RX;
                    end
                endcase
            end
            M_TX: begin
                next_s.mValid = 1'b1;
                if (s.cnt != s.len) begin
                    next_s.mData = s.buffer[s.cnt[2:0]];
                    next_s.sum   = addCarry(s.sum, s.buffer[s.cnt[2:0]]);
                    next_s.cnt   = s.cnt + 4'h1;
                end else begin
                    next_s.mData = ~s.sum;
                    next_s.done  = 1'b1;
                    next_s.ok    = 1'b1;
                    next_s.st    = M_IDLE;
                end
            end
            M_RX: begin
                // A silent slave is detected by the wait after the header or between bytes.
                next_s.waitCnt = s.waitCnt + 8'h01;
                if (link.sValid) begin
                    next_s.waitCnt = 8'h00;
                    if (s.cnt != s.len) begin
                        next_s.buffer[s.cnt[2:0]] = link.sData;
                        next_s.sum = addCarry(s.sum, link.sData);
                        next_s.cnt = s.cnt + 4'h1;
                    end else begin
                        next_s.ok   = (link.sData == ~s.sum);
                        next_s.done = 1'b1;
                        next_s.st   = M_IDLE;
                    end
                end else if (s.waitCnt == RESP_WAIT_CYC) begin
                    next_s.noResp = 1'b1;
                    next_s.done   = 1'b1;
                    next_s.st     = M_IDLE;
                end
            end
            default: begin
                next_s.st = M_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata        = s.rdata;
    assign busy          = (s.st != M_IDLE);
    assign link.pid      = s.pid;
    assign link.pidValid = s.pidValid;
    assign link.mData    = s.mData;
    assign link.mValid   = s.mValid;

endmodule : lsr_master_end
`default_nettype wire

// File: dv/lsr_link_properties.sv
// Checker of the link between the master end and the device end.
// Assumes one clock; it watches the link signals and drives nothing.
`timescale 1ns/10ps
`default_nettype none
module lsr_link_properties
    import lsr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] pid,
    input wire logic       pidValid,
    input wire logic [7:0] mData,
    input wire logic       mValid,
    input wire logic [7:0] sData,
    input wire logic       sValid
);
    logic [7:0] sAcc, sPrev, sLast, mAcc, mPrev, mLast;
    logic [5:0] hdrId;
    logic [8:0] sSum, mSum;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Running burst sums with the carry folded back in.
    assign sSum = {1'b0, sAcc} + {1'b0, sData};
    assign mSum = {1'b0, mAcc} + {1'b0, mData};
    // Sums clear between bursts, so a frame never inherits bytes of the last one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {sAcc, sPrev, sLast, mAcc, mPrev, mLast, hdrId} <= '0;
        end else begin
            sAcc  <= sValid ? sSum[7:0] + 8'(sSum[8]) : 8'h00;
            mAcc  <= mValid ? mSum[7:0] + 8'(mSum[8]) : 8'h00;
            sPrev <= sAcc;
            mPrev <= mAcc;
            sLast <= sData;
            mLast <= mData;
            if (pidValid) begin
                hdrId <= pid[5:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    pid_parity_a: assert property (pidValid |-> pid[6] == ^{pid[4], pid[2:0]} &&
        pid[7] == ~^{pid[5:3], pid[1]}) else $error("header parity wrong");
    answer_delay_a: assert property ($rose(sValid) |-> $past(pidValid, 2))
        else $error("answer not two cycles after header");
    quick_length_a: assert property ($rose(sValid) && hdrId != ID_READ |->
        sValid[*3] ##1 !sValid) else $error("quick answer length wrong");
    read_length_a: assert property ($rose(sValid) && hdrId == ID_READ |->
        sValid[*8] ##1 sValid ##1 !sValid) else $error("read answer length wrong");
    no_collision_a: assert property (!(mValid && sValid))
        else $error("both ends drive data at once");
    device_sum_a: assert property ($fell(sValid) |-> sLast == ~sPrev)
        else $error("device checksum wrong");
    master_sum_a: assert property ($fell(mValid) |-> mLast == ~mPrev)
        else $error("master checksum wrong");
    cmd_mark_a: assert property (pidValid ##1 mValid |-> mData[7])
        else $error("first data byte lacks mark bit");
    prep_wide_a: assert property (pidValid && pid[5:0] == ID_PREP8 |=>
        mValid && mData == APP_CMD ##1 mData[7] ##1 mData[7] ##1 (mData == FILL_BYTE)[*5])
        else $error("wide preparing frame layout wrong");
    ////////////////////////////////////////////////////////////////////////////////
    // Main traffic kinds seen on the link.
    prep_wide_c: cover property (pidValid && pid[5:0] == ID_PREP8);
    read_c: cover property ($rose(sValid) && hdrId == ID_READ);
    quick_c: cover property ($rose(sValid) && hdrId != ID_READ);
endmodule : lsr_link_properties
`default_nettype wire

// File: dv/tb_lin_status_otp_readback.sv
// Bench: master end and device end joined over the link.
// Assumes orders arrive over APB and device inputs are levels.
`timescale 1ns/10ps
`default_nettype none
module tb_lin_status_otp_readback;
    import lsr_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, b6 = 8'ha6, b7 = 8'hbd, b8 = 8'hba;
    logic [31:0] pwdata = '0, prdata, r, stat;
    logic        pready, pslverr, busy, statusFlags0, e;
    logic [6:0]  myAddr = 7'h2a;
    logic [5:0]  prepId = 6'h12, quickId = 6'h07, flagCause = 6'h00, statusFlags;
    logic [15:0] act = 16'hb1c2, tgt = 16'hd3e4;
    logic        endSw = 1'b1, otpWrEn = 1'b0;
    logic [1:0]  tInfo = 2'h2;
    logic [2:0]  otpWrAddr = 3'h0;
    logic [7:0]  otpWrData = 8'h00;
    lsr_bytes_t  otp = 64'h0f1e2d3c4b5a6978;
    int          failCount = 0, nTests = 0;
    lsr_link_if lnk();
    lsr_master_end lsr_master_end_inst (.clk(clk), .rst_n(rst_n), .link(lnk), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy));
    // Field inputs are slices of the expected bytes.
    lsr_dev_end lsr_dev_end_inst (.clk(clk), .rst_n(rst_n), .link(lnk),
        .nodeAddress(myAddr), .prepareId(prepId), .quickStatusId(quickId),
        .actualPosition(act), .targetPosition(tgt), .securePosition({b7[2:0], b6}),
        .fullstepStallEnable(b7[7:5]), .fullDutyFlag(b7[3]), .fullDutyStallEnable(b8[1]),
        .absoluteStallFlag(b8[7]), .deltaStallLowFlag(b8[6]), .deltaStallHighFlag(b8[5]),
        .stallMinSampleCount(b8[4:2]), .pwmJitterEnable(b8[0]), .endSwitchState(endSw),
        .flagCause(flagCause), .tempInfo(tInfo), .otpWrEn(otpWrEn), .otpWrAddr(otpWrAddr),
        .otpWrData(otpWrData), .statusFlags0(statusFlags0), .statusFlags(statusFlags));
    lsr_link_properties lsr_link_properties_inst (.clk(clk), .rst_n(rst_n), .pid(lnk.pid),
        .pidValid(lnk.pidValid), .mData(lnk.mData), .mValid(lnk.mValid),
        .sData(lnk.sData), .sValid(lnk.sValid));
    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    // Compares and counts; an unknown bit matches only an unknown bit.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Orders one frame and polls until the master is idle again.
    task automatic frame(input logic [1:0] k, input logic [5:0] id, input logic [6:0] c,
                         input logic [6:0] a);
        apb(1'b1, REG_CTRL, {1'b0, a, 1'b0, c, 2'b00, id, 6'h00, k});
        for (int i = 0; i < 40 && (i == 0 || stat[0] !== 1'b0); i++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            stat = r;
        end
        check("busy", 32'(busy), 32'h0);
    endtask : frame
    task automatic complete_run();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    // A hang ends the run; every sequence here needs under a hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            otpWrEn <= 1'b1;
            otpWrAddr <= 3'(i);
            otpWrData <= otp[i];
        end
        @(posedge clk);
        otpWrEn <= 1'b0;
        // The segment comes back through either preparing form.
        for (int k = 0; k < 2; k++) begin
            frame(2'(k), k ? ID_PREP8 : prepId, CMD_OTP, myAddr);
            frame(KIND_READ, ID_READ, 7'h00, 7'h00);
            check("otp status", 32'(stat[3:1]), 32'h3);
            apb(1'b0, REG_RD0, 32'h0);
            check("otp low", r, otp[3:0]);
            apb(1'b0, REG_RD1, 32'h0);
            check("otp high", r, otp[7:4]);
        end
        frame(KIND_PREP8, ID_PREP8, CMD_FULL, myAddr);
        frame(KIND_READ, ID_READ, 7'h00, 7'h00);
        apb(1'b0, REG_RD0, 32'h0);
        check("positions", r, {tgt[15:8], act[7:0], act[15:8], 1'b1, myAddr});
        apb(1'b0, REG_RD1, 32'h0);
        check("stall bytes", r, {b8, b7, b6, tgt[7:0]});
        // A foreign address must leave the read unanswered.
        frame(KIND_PREP7, prepId, CMD_OTP, 7'h15);
        frame(KIND_READ, ID_READ, 7'h00, 7'h00);
        check("foreign silent", 32'(stat[3]), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", {r[30:0], e}, 32'h1);
        // A pulsed cause is cleared by the report, a held one stays.
        @(posedge clk);
        flagCause <= 6'h2d;
        @(posedge clk);
        flagCause <= 6'h01;
        frame(KIND_QUICK, quickId, 7'h00, 7'h00);
        apb(1'b0, REG_RD0, 32'h0);
        check("quick first", r, {16'h0, 6'h2d, tInfo, endSw, myAddr});
        check("flags kept", 32'({statusFlags, statusFlags0}), 32'h3);
        frame(KIND_QUICK, quickId, 7'h00, 7'h00);
        apb(1'b0, REG_RD0, 32'h0);
        check("quick second", r, {16'h0, 6'h01, tInfo, endSw, myAddr});
        complete_run();
    end
endmodule : tb_lin_status_otp_readback
`default_nettype wire
